// [hdl/ufa_data_fifo.v]
// UART receive/transmit data path with FIFOs, data alias, test access and APB slave
`include "ufa_defines.vh"

module ufa_data_fifo (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    // Serial link
    input wire sampleTick,
    input wire sin,
    input wire sirIn,
    output reg sout,
    output reg sirOutN,
    // Interrupt
    output wire irq
);

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function isAlias;
        input [31:0] a;
        begin
            isAlias = (a >= `UFA_ALIAS_FIRST) && (a <= `UFA_ALIAS_LAST) && (a[1:0] == 2'h0);
        end
    endfunction

    function isMapped;
        input [31:0] a;
        begin
            isMapped = isAlias(a) || a == `UFA_TEST_ACCESS || a == `UFA_CTRL
                || a == `UFA_STATUS || a == `UFA_INT_STAT || a == `UFA_INT_CLR
                || a == `UFA_INT_EN;
        end
    endfunction

    wire setupPh = psel & ~penable;
    wire accessPh = psel & penable;
    wire wrAcc = accessPh & pwrite & isMapped(paddr);
    wire rdAcc = accessPh & ~pwrite & isMapped(paddr);
    assign pready = 1'b1;
    assign pslverr = accessPh & ~isMapped(paddr);

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    reg [1:0] ctrlQ;
    reg testQ;
    reg [`UFA_EV_W-1:0] intEnQ;
    reg [`UFA_EV_W-1:0] intStatQ;
    wire fifoEn = ctrlQ[`UFA_CTRL_FIFO_EN];
    wire irMode = ctrlQ[`UFA_CTRL_IR_MODE];
    wire testWr = wrAcc && paddr == `UFA_TEST_ACCESS && `UFA_FIFO_ACCESS_CFG;
    wire testToggle = testWr && pwdata[0] != testQ;
    wire ctrlWr = wrAcc && paddr == `UFA_CTRL;
    wire fifoToggle = ctrlWr && pwdata[`UFA_CTRL_FIFO_EN] != fifoEn;
    // A FIFO-enable or test-access change leaves stale pointers meaningless, so both FIFOs restart
    wire fifoClr = testToggle | fifoToggle;
    wire aliasWr = wrAcc & isAlias(paddr);
    wire aliasRd = rdAcc & isAlias(paddr);

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlQ <= `UFA_CTRL_RST;
            testQ <= `UFA_TEST_ACCESS_RST;
            intEnQ <= `UFA_INT_EN_RST;
        end else begin
            if (ctrlWr) begin
                ctrlQ <= pwdata[1:0];
            end
            if (testWr) begin
                testQ <= pwdata[0];
            end
            if (wrAcc && paddr == `UFA_INT_EN) begin
                intEnQ <= pwdata[`UFA_EV_W-1:0];
            end
        end
    end

    // ----------------------------------------
    // Receive FIFO
    // ----------------------------------------
    reg [7:0] rxMem [0:`UFA_FIFO_DEPTH-1];
    reg [`UFA_PTR_W-1:0] rxWrQ;
    reg [`UFA_PTR_W-1:0] rxRdQ;
    reg [`UFA_CNT_W-1:0] rxCntQ;
    reg rxDoneQ;
    reg [7:0] rxByteQ;
    wire [`UFA_CNT_W-1:0] rxCap = fifoEn ? `UFA_FIFO_CAP : `UFA_SINGLE_CAP;
    wire rxFull = rxCntQ == rxCap;
    wire rxEmpty = rxCntQ == 0;
    // Receiver pushes only outside test mode; in test mode the master does
    wire rxPushReq = testQ ? aliasWr : rxDoneQ;
    wire [7:0] rxPushData = testQ ? pwdata[7:0] : rxByteQ;
    reg rdValidQ;
    wire rxPop = aliasRd & ~testQ & rdValidQ & ~fifoClr;
    wire rxPush = rxPushReq & ~rxFull & ~fifoClr;
    wire rxOver = rxPushReq & rxFull & ~fifoClr & ~testQ & ~rxPop;
    // Non-FIFO mode: unread byte is overwritten in place
    wire rxOverwrite = rxOver & ~fifoEn;

    always @(posedge core_clk) begin
        if (rxPush) begin
            rxMem[rxWrQ] <= rxPushData;
        end else if (rxOverwrite) begin
            rxMem[rxRdQ] <= rxPushData;
        end else if (rxPushReq && rxPop && rxFull && !fifoClr) begin
            rxMem[rxWrQ] <= rxPushData;
        end
    end

    wire rxPushPop = rxPushReq & rxPop & rxFull & ~fifoClr;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxWrQ <= {`UFA_PTR_W{1'b0}};
            rxRdQ <= {`UFA_PTR_W{1'b0}};
            rxCntQ <= {`UFA_CNT_W{1'b0}};
        end else if (fifoClr) begin
            rxWrQ <= {`UFA_PTR_W{1'b0}};
            rxRdQ <= {`UFA_PTR_W{1'b0}};
            rxCntQ <= {`UFA_CNT_W{1'b0}};
        end else begin
            // Full FIFO with no read: newcomer is simply dropped
            if (rxPush || rxPushPop) begin
                rxWrQ <= fifoEn ? rxWrQ + 1'b1 : rxWrQ;
            end
            if (rxPop) begin
                rxRdQ <= fifoEn ? rxRdQ + 1'b1 : rxRdQ;
            end
            if (rxPush && !rxPop) begin
                rxCntQ <= rxCntQ + 1'b1;
            end else if (rxPop && !rxPush && !rxPushPop) begin
                rxCntQ <= rxCntQ - 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Transmit FIFO
    // ----------------------------------------
    reg [7:0] txMem [0:`UFA_FIFO_DEPTH-1];
    reg [`UFA_PTR_W-1:0] txWrQ;
    reg [`UFA_PTR_W-1:0] txRdQ;
    reg [`UFA_CNT_W-1:0] txCntQ;
    wire txFull = txCntQ == rxCap;
    wire txEmpty = txCntQ == 0;
    reg txBusyQ;
    wire txWrReq = aliasWr & ~testQ;
    wire txLoad = ~testQ & ~txBusyQ & ~txEmpty & ~fifoClr;
    wire txPop = (txLoad | (aliasRd & testQ & rdValidQ)) & ~fifoClr;
    wire txPush = txWrReq & ~txFull & ~fifoClr;
    // Single holding register already occupied: replace pending byte
    wire txReplace = txWrReq & txFull & ~fifoEn & ~txPop & ~fifoClr;
    wire txLost = txWrReq & txFull & fifoEn & ~fifoClr;

    always @(posedge core_clk) begin
        if (txPush) begin
            txMem[txWrQ] <= pwdata[7:0];
        end else if (txReplace) begin
            txMem[txRdQ] <= pwdata[7:0];
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            txWrQ <= {`UFA_PTR_W{1'b0}};
            txRdQ <= {`UFA_PTR_W{1'b0}};
            txCntQ <= {`UFA_CNT_W{1'b0}};
        end else if (fifoClr) begin
            txWrQ <= {`UFA_PTR_W{1'b0}};
            txRdQ <= {`UFA_PTR_W{1'b0}};
            txCntQ <= {`UFA_CNT_W{1'b0}};
        end else begin
            if (txPush) begin
                txWrQ <= fifoEn ? txWrQ + 1'b1 : txWrQ;
            end
            if (txPop) begin
                txRdQ <= fifoEn ? txRdQ + 1'b1 : txRdQ;
            end
            if (txPush && !txPop) begin
                txCntQ <= txCntQ + 1'b1;
            end else if (txPop && !txPush) begin
                txCntQ <= txCntQ - 1'b1;
            end
        end
    end

    // ----------------------------------------
    // APB read data
    // ----------------------------------------
    // Data is latched in setup so the output comes from a flop; the pop
    // happens only at the access edge, and only if data was valid then.
    reg [31:0] rdMux;
    always @* begin
        rdMux = 32'h0;
        if (isAlias(paddr)) begin
            rdMux[7:0] = testQ ? txMem[txRdQ] : rxMem[rxRdQ];
        end else if (paddr == `UFA_TEST_ACCESS) begin
            rdMux[0] = testQ;
        end else if (paddr == `UFA_CTRL) begin
            rdMux[1:0] = ctrlQ;
        end else if (paddr == `UFA_STATUS) begin
            rdMux[`UFA_ST_DATA_READY] = ~rxEmpty;
            rdMux[`UFA_ST_THR_EMPTY] = txEmpty;
            rdMux[`UFA_ST_RX_FULL] = rxCntQ == `UFA_FIFO_DEPTH;
            rdMux[`UFA_ST_TX_FULL] = txFull;
        end else if (paddr == `UFA_INT_STAT) begin
            rdMux[`UFA_EV_W-1:0] = intStatQ;
        end else if (paddr == `UFA_INT_EN) begin
            rdMux[`UFA_EV_W-1:0] = intEnQ;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0;
            rdValidQ <= 1'b0;
        end else if (setupPh && !pwrite) begin
            prdata <= rdMux;
            rdValidQ <= testQ ? ~txEmpty : ~rxEmpty;
        end
    end

    // ----------------------------------------
    // Interrupt status
    // ----------------------------------------
    wire [`UFA_EV_W-1:0] evSet = {txLost, txLoad & (txCntQ == 1) & ~txPush,
        rxOver, rxPush | rxOverwrite | rxPushPop};
    wire [`UFA_EV_W-1:0] evClr = (wrAcc && paddr == `UFA_INT_CLR) ?
        pwdata[`UFA_EV_W-1:0] : {`UFA_EV_W{1'b0}};
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            intStatQ <= {`UFA_EV_W{1'b0}};
        end else begin
            // Set wins over a simultaneous clear
            intStatQ <= (intStatQ & ~evClr) | evSet;
        end
    end
    assign irq = |(intStatQ & intEnQ);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    reg sinMetaQ;
    reg sinSyncQ;
    reg irMetaQ;
    reg irSyncQ;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sinMetaQ <= 1'b1;
            sinSyncQ <= 1'b1;
            irMetaQ <= 1'b0;
            irSyncQ <= 1'b0;
        end else begin
            sinMetaQ <= sin;
            sinSyncQ <= sinMetaQ;
            irMetaQ <= sirIn;
            irSyncQ <= irMetaQ;
        end
    end
    // Infrared pulse means a zero bit
    wire rxLine = irMode ? ~irSyncQ : sinSyncQ;

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    reg rxActQ;
    reg [3:0] rxTickQ;
    reg [3:0] rxBitQ;
    reg [7:0] rxShQ;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxActQ <= 1'b0;
            rxTickQ <= 4'h0;
            rxBitQ <= 4'h0;
            rxShQ <= 8'h0;
            rxByteQ <= 8'h0;
            rxDoneQ <= 1'b0;
        end else begin
            rxDoneQ <= 1'b0;
            if (sampleTick) begin
                if (!rxActQ) begin
                    if (!rxLine) begin
                        rxActQ <= 1'b1;
                        // Infrared start is only seen mid-pulse: sample on the next tick
                        rxTickQ <= irMode ? `UFA_OVS_MID : 4'h0;
                        rxBitQ <= 4'h0;
                    end
                end else begin
                    rxTickQ <= rxTickQ + 1'b1;
                    if (rxTickQ == `UFA_OVS_MID) begin
                        rxBitQ <= rxBitQ + 1'b1;
                        if (rxBitQ == 4'h0 && rxLine) begin
                            rxActQ <= 1'b0; // false start
                        end else if (rxBitQ == `UFA_FRAME_BITS) begin
                            rxActQ <= 1'b0;
                            rxByteQ <= rxShQ;
                            rxDoneQ <= 1'b1;
                        end else if (rxBitQ != 4'h0) begin
                            rxShQ <= {rxLine, rxShQ[7:1]};
                        end
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    reg [9:0] txShQ;
    reg [3:0] txTickQ;
    reg [3:0] txBitQ;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            txBusyQ <= 1'b0;
            txShQ <= 10'h3ff;
            txTickQ <= 4'h0;
            txBitQ <= 4'h0;
        end else if (txLoad) begin
            txBusyQ <= 1'b1;
            txShQ <= {1'b1, txMem[txRdQ], 1'b0};
            txTickQ <= 4'h0;
            txBitQ <= 4'h0;
        end else if (txBusyQ && sampleTick) begin
            txTickQ <= txTickQ + 1'b1;
            if (txTickQ == `UFA_OVS_LAST) begin
                txShQ <= {1'b1, txShQ[9:1]};
                txBitQ <= txBitQ + 1'b1;
                if (txBitQ == `UFA_FRAME_BITS) begin
                    txBusyQ <= 1'b0;
                end
            end
        end
    end

    wire txBit = txBusyQ ? txShQ[0] : 1'b1;
    wire irPulse = txTickQ >= `UFA_IR_PULSE_FIRST && txTickQ <= `UFA_IR_PULSE_LAST;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sout <= 1'b1;
            sirOutN <= 1'b1;
        end else begin
            sout <= irMode ? 1'b1 : txBit;
            sirOutN <= irMode ? ~(~txBit & irPulse) : 1'b1;
        end
    end

endmodule

// [include/ufa_defines.vh]
// Register map, field positions, reset values and sizes of the UART data path
`ifndef UFA_DEFINES_VH
`define UFA_DEFINES_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define UFA_ALIAS_FIRST 32'h50001130
`define UFA_ALIAS_LAST 32'h5000116c
`define UFA_TEST_ACCESS 32'h50001170
`define UFA_CTRL 32'h50001180
`define UFA_STATUS 32'h50001184
`define UFA_INT_STAT 32'h50001188
`define UFA_INT_CLR 32'h5000118c
`define UFA_INT_EN 32'h50001190
// ----------------------------------------
// Field positions
// ----------------------------------------
`define UFA_CTRL_FIFO_EN 0
`define UFA_CTRL_IR_MODE 1
`define UFA_ST_DATA_READY 0
`define UFA_ST_THR_EMPTY 1
`define UFA_ST_RX_FULL 2
`define UFA_ST_TX_FULL 3
`define UFA_EV_RX_CHAR 0
`define UFA_EV_OVERRUN 1
`define UFA_EV_TX_EMPTY 2
`define UFA_EV_TX_LOST 3
`define UFA_EV_W 4
// ----------------------------------------
// Reset values, sizes and timing
// ----------------------------------------
`define UFA_CTRL_RST 2'h0
`define UFA_TEST_ACCESS_RST 1'h0
`define UFA_INT_EN_RST 4'h0
`define UFA_FIFO_DEPTH 16
`define UFA_PTR_W 4
`define UFA_CNT_W 5
`define UFA_FIFO_CAP 5'h10
`define UFA_SINGLE_CAP 5'h1
`define UFA_FIFO_ACCESS_CFG 1'h1
`define UFA_OVS 16
`define UFA_OVS_MID 4'h7
`define UFA_OVS_LAST 4'hf
`define UFA_IR_PULSE_FIRST 4'h6
`define UFA_IR_PULSE_LAST 4'h8
`define UFA_FRAME_BITS 4'h9
`endif

// [verification/uart_data_fifo_access_tb.sv]
// Self-checking bench for the UART data path
`include "ufa_defines.vh"
module uart_data_fifo_access_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, rst_n, psel, penable, pwrite, sampleTick, irMode, se;
    logic [31:0] paddr, pwdata, rd;
    logic [7:0] b;
    wire [31:0] prdata;
    wire pready, pslverr, sout, sirOutN, irq, sin, sirIn;
    int errTotal, testsRun, cyc;
    ufa_data_fifo dut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .pslverr, .prdata, .sampleTick, .sin, .sirIn, .sout, .sirOutN, .irq);
    ufa_serial_peer peer (.core_clk, .sampleTick, .irMode, .sout, .sirOutN, .sin, .sirIn);
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Tick every other cycle keeps a frame at 320 cycles
    always @(posedge core_clk) begin
        sampleTick <= ~sampleTick;
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errTotal++;
            results();
        end
    end
    task automatic results();
        if (errTotal == 0 && testsRun > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            errTotal++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Idle cycle after release so back-to-back calls never drive twice in one step
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rdChk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    initial begin
        {rst_n, psel, penable, pwrite, sampleTick, irMode} = 6'h00;
        {paddr, pwdata, errTotal, testsRun, cyc} = 0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rdChk(`UFA_TEST_ACCESS, ~32'h0, 32'h0);
        rdChk(`UFA_STATUS, ~32'h0, 32'h2);
        rdChk(`UFA_INT_EN, ~32'h0, 32'h0);
        bus(1'b0, `UFA_ALIAS_FIRST - 32'h4, 32'h0);
        chk({rd[30:0], se}, 32'h1);
        peer.sendByte(8'h5a);
        peer.sendByte(8'ha3);
        rdChk(`UFA_INT_STAT, ~32'h0, 32'h3);
        rdChk(`UFA_ALIAS_LAST, ~32'h0, 32'ha3);
        rdChk(`UFA_STATUS, 32'h1, 32'h0);
        bus(1'b1, `UFA_INT_EN, 32'h2);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, `UFA_INT_EN, 32'h0);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, `UFA_INT_CLR, 32'hf);
        bus(1'b1, `UFA_INT_EN, 32'hf);
        chk({31'h0, irq}, 32'h0);
        rdChk(`UFA_STATUS, 32'h2, 32'h2);
        fork
            begin
                peer.getByte(b);
                chk({24'h0, b}, 32'h11);
                peer.getByte(b);
                chk({24'h0, b}, 32'h33);
            end
        join_none
        bus(1'b1, `UFA_ALIAS_FIRST, 32'h11);
        bus(1'b1, `UFA_ALIAS_FIRST + 32'h4, 32'h22);
        rdChk(`UFA_STATUS, 32'h2, 32'h0);
        bus(1'b1, `UFA_ALIAS_LAST, 32'h33);
        wait fork;
        bus(1'b1, `UFA_CTRL, 32'h1);
        fork
            for (int i = 0; i < 17; i++) begin
                peer.getByte(b);
                chk({24'h0, b}, 32'h40 + i);
            end
        join_none
        for (int i = 0; i < 17; i++) bus(1'b1, `UFA_ALIAS_FIRST + 4 * (i % 16), 32'h40 + i);
        rdChk(`UFA_STATUS, 32'h8, 32'h8);
        bus(1'b1, `UFA_ALIAS_FIRST, 32'hee);
        rdChk(`UFA_INT_STAT, 32'h8, 32'h8);
        wait fork;
        for (int i = 0; i < 17; i++) peer.sendByte(8'h80 + i[7:0]);
        rdChk(`UFA_STATUS, 32'h5, 32'h5);
        rdChk(`UFA_INT_STAT, 32'h2, 32'h2);
        for (int i = 0; i < 15; i++) rdChk(`UFA_ALIAS_FIRST, ~32'h0, 32'h80 + i);
        rdChk(`UFA_STATUS, 32'h5, 32'h1);
        bus(1'b1, `UFA_TEST_ACCESS, 32'h1);
        rdChk(`UFA_TEST_ACCESS, ~32'h0, 32'h1);
        rdChk(`UFA_STATUS, 32'h1, 32'h0);
        for (int i = 0; i < 16; i++) bus(1'b1, `UFA_ALIAS_LAST, 32'h60);
        bus(1'b0, `UFA_ALIAS_LAST, 32'h0);
        rdChk(`UFA_STATUS, 32'h5, 32'h5);
        bus(1'b1, `UFA_TEST_ACCESS, 32'h0);
        rdChk(`UFA_STATUS, 32'h5, 32'h0);
        bus(1'b1, `UFA_CTRL, 32'h0);
        bus(1'b1, `UFA_TEST_ACCESS, 32'h1);
        bus(1'b1, `UFA_ALIAS_FIRST, 32'h77);
        rdChk(`UFA_STATUS, 32'h5, 32'h1);
        bus(1'b1, `UFA_TEST_ACCESS, 32'h0);
        bus(1'b1, `UFA_CTRL, 32'h2);
        irMode = 1'b1;
        peer.sendByte(8'hc5);
        rdChk(`UFA_ALIAS_FIRST, ~32'h0, 32'hc5);
        fork
            peer.getByte(b);
        join_none
        bus(1'b1, `UFA_ALIAS_FIRST, 32'h96);
        wait fork;
        chk({24'h0, b}, 32'h96);
        results();
    end
endmodule

// [verification/ufa_data_fifo_props.sv]
// Port checker for the UART data path
`include "ufa_defines.vh"
module ufa_data_fifo_props (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Bus
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire pslverr,
    input wire [31:0] prdata,
    // Serial
    input wire sampleTick,
    input wire sout,
    input wire sirOutN
);
    timeunit 1ns;
    timeprecision 1ns;
    logic irMode_q, testAcc_q, tickDly_q;
    logic [7:0] soutLow_q, irLow_q;
    wire wrAcc = psel && penable && pwrite;
    wire rdSetup = psel && !penable && !pwrite;
    wire inAlias = paddr >= `UFA_ALIAS_FIRST && paddr <= `UFA_ALIAS_LAST
        && paddr[1:0] == 2'h0;
    // ----------------------------------------
    // Mode shadow and low-time tick counters
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irMode_q <= 1'b0;
            testAcc_q <= 1'b0;
            tickDly_q <= 1'b0;
            soutLow_q <= 8'h00;
            irLow_q <= 8'h00;
        end else begin
            // Outputs are registered one cycle after the tick that moves them
            tickDly_q <= sampleTick;
            if (wrAcc && paddr == `UFA_CTRL) irMode_q <= pwdata[1];
            if (wrAcc && paddr == `UFA_TEST_ACCESS) testAcc_q <= pwdata[0];
            soutLow_q <= sout ? 8'h00 : soutLow_q + {7'h00, tickDly_q};
            irLow_q <= sirOutN ? 8'h00 : irLow_q + {7'h00, tickDly_q};
        end
    end
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    a_ir_sout_idle: assert property (irMode_q && $past(irMode_q) |-> sout)
        else $error("sout low in infrared mode");
    a_plain_ir_idle: assert property (!irMode_q && !$past(irMode_q) |-> sirOutN)
        else $error("infrared output low in normal mode");
    a_frame_bit_len: assert property ($rose(sout) |-> soutLow_q != 0 && soutLow_q[3:0] == 0)
        else $error("sout low time not whole bits");
    a_ir_pulse_len: assert property ($rose(sirOutN) |-> irLow_q == 8'h03)
        else $error("infrared pulse not three ticks");
    a_test_access_rd: assert property (
        rdSetup && paddr == `UFA_TEST_ACCESS |=> prdata == {31'h0, testAcc_q})
        else $error("test access bit reads wrong");
    a_alias_upper_zero: assert property (rdSetup && inAlias |=> prdata[31:8] == 24'h0)
        else $error("alias read upper bits set");
    a_alias_no_err: assert property (psel && penable && inAlias |-> !pslverr)
        else $error("alias access refused");
    a_below_alias_err: assert property (
        psel && penable && paddr == `UFA_ALIAS_FIRST - 32'h4 |-> pslverr)
        else $error("address below alias accepted");
endmodule

bind ufa_data_fifo ufa_data_fifo_props props (.core_clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pslverr, .prdata, .sampleTick, .sout, .sirOutN);

// [verification/ufa_serial_peer.sv]
// Model of the remote serial port facing the UART data path
module ufa_serial_peer (
    // Clock, tick and mode
    input wire core_clk,
    input wire sampleTick,
    input wire irMode,
    // From the device
    input wire sout,
    input wire sirOutN,
    // To the device
    output logic sin,
    output logic sirIn
);
    timeunit 1ns;
    timeprecision 1ns;
    wire line = irMode ? sirOutN : sout;
    initial begin
        sin = 1'b1;
        sirIn = 1'b0;
    end
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge core_clk);
            while (sampleTick !== 1'b1) @(posedge core_clk);
        end
    endtask
    // 8N1, LSB first; infrared zero is a high pulse on ticks 6..8
    task automatic sendByte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            for (int t = 0; t < 16; t++) begin
                sin <= irMode ? 1'b1 : f[i];
                sirIn <= irMode && !f[i] && t >= 6 && t <= 8;
                ticks(1);
            end
        end
        sirIn <= 1'b0;
    endtask
    // Majority over each bit window (any pulse in infrared mode) tolerates a tick of misalignment
    task automatic getByte(output logic [7:0] b);
        int lows;
        while (line !== 1'b1) @(posedge core_clk);
        while (line !== 1'b0) @(posedge core_clk);
        ticks(irMode ? 10 : 16);
        for (int k = 0; k < 8; k++) begin
            lows = 0;
            for (int t = 0; t < 16; t++) begin
                ticks(1);
                lows += (line === 1'b0);
            end
            b[k] = irMode ? (lows == 0) : (lows < 8);
        end
    endtask
endmodule
